// *** uls_ext_status.sv ***
// Extended status, control and pin logic of the serial port, with APB register access
`timescale 1ns/100ps
`include "uls_cfg.svh"

module uls_ext_status (
  input wire logic pclk, // Bus clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic baud_tick, // One pulse per bit time
  input wire logic data_9bit, // Data-length control bit
  input wire logic receiver_standby, // Receiver in wakeup standby
  input wire logic loopback_select, // Loop mode select
  input wire logic receiver_source_select, // Single-wire source select
  input wire logic serial_in_pin, // Receive pin level
  output logic rx_line, // Receive level after inversion
  input wire uls_pkg::uls_rx_char_t rx_char, // Character from receive shifter
  output logic rx_full_set, // Pulse to set receive-full flag
  output logic framing_set, // Pulse to set framing flag
  output logic idle_set, // Pulse to set idle flag
  output logic break_detect, // Pulse on received break
  output logic [3:0] frame_bits, // Bits per frame
  input wire uls_pkg::uls_err_flags_t err_flags, // Status flags from status register
  output logic irq_req, // Error interrupt request
  input wire logic data_write, // Pulse: data buffer written
  input wire logic [7:0] data_byte, // Byte written to data buffer
  output uls_pkg::uls_tx_load_t tx_load, // Word to transmit shifter
  input wire logic tx_line, // Raw transmit level from shifter
  output logic serial_out_pin, // Transmit pin level
  output logic serial_out_oe // Transmit pin drive enable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic lin_break_flag_q, lin_break_flag_d;
  logic rx_edge_flag_q, rx_edge_flag_d;
  logic [3:0] ctl_status_q;
  logic rx_ninth_bit_q;
  logic [6:0] ctl_ninth_q;
  uls_pkg::uls_rx_state_t rx_state_q, rx_state_d;
  logic [3:0] low_cnt_q, low_cnt_d;
  logic [3:0] high_cnt_q, high_cnt_d;
  logic rx_prev_q;
  uls_pkg::uls_tx_load_t tx_load_q;
  logic [31:0] prdata_q;

  // Named control fields
  wire rx_invert = ctl_status_q[`ULS_B_RX_INV - 1];
  wire wake_idle_flag_select = ctl_status_q[`ULS_B_WAKE_SEL - 1];
  wire long_break_tx = ctl_status_q[`ULS_B_LONG_BRK - 1];
  wire lin_break_detect_enable = ctl_status_q[`ULS_B_LBK_EN - 1];
  wire receiver_active_flag = (rx_state_q == uls_pkg::ULS_RX_ACTIVE);
  wire tx_ninth_bit = ctl_ninth_q[`ULS_B_TX_NINTH];
  wire single_wire_pin_direction = ctl_ninth_q[`ULS_B_PIN_DIR];
  wire tx_invert = ctl_ninth_q[`ULS_B_TX_INV];
  wire overrun_irq_enable = ctl_ninth_q[`ULS_B_OR_IE];
  wire noise_irq_enable = ctl_ninth_q[`ULS_B_NF_IE];
  wire framing_irq_enable = ctl_ninth_q[`ULS_B_FE_IE];
  wire parity_irq_enable = ctl_ninth_q[`ULS_B_PF_IE];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Offset match, shared by read and write paths
  function automatic logic at_off(input logic [11:0] a, input logic [11:0] off);
    at_off = (a == off);
  endfunction

  wire hit_lin_edge = at_off(paddr, `ULS_OFF_LIN_EDGE);
  wire hit_ninth = at_off(paddr, `ULS_OFF_NINTH_IRQ);
  wire mapped = hit_lin_edge || hit_ninth;
  // Frozen clock enable stalls the bus so no write is lost
  wire acc = psel && penable && clk_en;
  wire wr_lin_edge = acc && pwrite && hit_lin_edge;
  wire wr_ninth = acc && pwrite && hit_ninth;

  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;

  // Read view, bits above the byte read as zero
  wire [7:0] rd_lin_edge = {lin_break_flag_q, rx_edge_flag_q, 1'b0, ctl_status_q,
                            receiver_active_flag};
  wire [7:0] rd_ninth = {rx_ninth_bit_q, ctl_ninth_q};
  logic [7:0] rd_byte;
  always_comb begin
    if (hit_lin_edge) begin
      rd_byte = rd_lin_edge;
    end else if (hit_ninth) begin
      rd_byte = rd_ninth;
    end else begin
      rd_byte = `ULS_RST_BYTE;
    end
  end

  // Read data captured at the setup cycle, valid through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Receive line and edge detection
  // ----------------------------------------------------------------
  // Inversion ahead of all receive logic
  assign rx_line = serial_in_pin ^ rx_invert;
  // Falling edge of the corrected line is the active pin edge
  wire edge_evt = rx_prev_q && !rx_line;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q <= 1'b1;
    end else if (clk_en) begin
      rx_prev_q <= rx_line;
    end
  end

  // ----------------------------------------------------------------
  // Bit-time counters: break and idle
  // ----------------------------------------------------------------
  assign frame_bits = data_9bit ? `ULS_FRAME_9 : `ULS_FRAME_8;
  // Break threshold is one frame, one bit longer with break detection on
  wire [3:0] brk_thr = frame_bits + (lin_break_detect_enable ? `ULS_LBK_ADD : 4'h0);

  // Counters saturate so a long low or high is reported once
  always_comb begin
    low_cnt_d = low_cnt_q;
    high_cnt_d = high_cnt_q;
    if (baud_tick) begin
      if (!rx_line) begin
        low_cnt_d = (low_cnt_q == 4'hf) ? low_cnt_q : low_cnt_q + 4'h1;
        high_cnt_d = 4'h0;
      end else begin
        high_cnt_d = (high_cnt_q == 4'hf) ? high_cnt_q : high_cnt_q + 4'h1;
        low_cnt_d = 4'h0;
      end
    end
  end

  assign break_detect = baud_tick && !rx_line && (low_cnt_d == brk_thr);
  wire idle_evt = receiver_active_flag && baud_tick && rx_line && (high_cnt_d == frame_bits);

  // ----------------------------------------------------------------
  // Receiver active state machine
  // ----------------------------------------------------------------
  // Active from a start edge until a full frame of idle line
  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      uls_pkg::ULS_RX_IDLE: begin
        if (edge_evt) begin
          rx_state_d = uls_pkg::ULS_RX_ACTIVE;
        end
      end
      uls_pkg::ULS_RX_ACTIVE: begin
        if (idle_evt) begin
          rx_state_d = uls_pkg::ULS_RX_IDLE;
        end
      end
      default: rx_state_d = uls_pkg::ULS_RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= uls_pkg::ULS_RX_IDLE;
      low_cnt_q <= 4'h0;
      high_cnt_q <= 4'h0;
    end else if (clk_en) begin
      rx_state_q <= rx_state_d;
      low_cnt_q <= low_cnt_d;
      high_cnt_q <= high_cnt_d;
    end
  end

  // Idle flag reported in standby only when selected
  assign idle_set = clk_en && idle_evt && (!receiver_standby || wake_idle_flag_select);

  // ----------------------------------------------------------------
  // Receive character gating
  // ----------------------------------------------------------------
  // Break detection hides every received character; stop fault ignores long_break_tx
  assign rx_full_set = clk_en && rx_char.done && !lin_break_detect_enable;
  assign framing_set = clk_en && rx_char.done && rx_char.stop_fault
                       && !lin_break_detect_enable;

  // ----------------------------------------------------------------
  // Flags with write-one-to-clear; a same-cycle event wins
  // ----------------------------------------------------------------
  always_comb begin
    lin_break_flag_d = lin_break_flag_q;
    rx_edge_flag_d = rx_edge_flag_q;
    if (wr_lin_edge && pwdata[`ULS_B_LBK_FLAG]) begin
      lin_break_flag_d = 1'b0;
    end
    if (wr_lin_edge && pwdata[`ULS_B_EDGE_FLAG]) begin
      rx_edge_flag_d = 1'b0;
    end
    if (break_detect && lin_break_detect_enable) begin
      lin_break_flag_d = 1'b1;
    end
    if (edge_evt) begin
      rx_edge_flag_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // Receiver active bit is not writable, so only bits 4..1 are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_break_flag_q <= 1'b0;
      rx_edge_flag_q <= 1'b0;
      ctl_status_q <= 4'h0;
      ctl_ninth_q <= 7'h00;
    end else if (clk_en) begin
      lin_break_flag_q <= lin_break_flag_d;
      rx_edge_flag_q <= rx_edge_flag_d;
      if (wr_lin_edge) begin
        ctl_status_q <= pwdata[`ULS_B_RX_INV:`ULS_B_LBK_EN];
      end
      if (wr_ninth) begin
        ctl_ninth_q <= pwdata[`ULS_B_TX_NINTH:`ULS_B_PF_IE];
      end
    end
  end

  // Ninth received bit follows each character accepted into the buffer in 9-bit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ninth_bit_q <= 1'b0;
    end else if (rx_full_set && data_9bit) begin
      rx_ninth_bit_q <= rx_char.data[8];
    end
  end

  // ----------------------------------------------------------------
  // Transmit load and break length
  // ----------------------------------------------------------------
  // Word taken whole on a data write; tx_ninth_bit itself is kept
  wire [3:0] brk_len = frame_bits + (long_break_tx ? `ULS_BRK_LONG_ADD : 4'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load_q <= '0;
    end else if (clk_en) begin
      tx_load_q.load <= data_write;
      tx_load_q.break_bits <= brk_len;
      if (data_write) begin
        tx_load_q.word <= {data_9bit & tx_ninth_bit, data_byte};
      end
    end
  end
  assign tx_load = tx_load_q;

  // ----------------------------------------------------------------
  // Transmit pin and interrupt request
  // ----------------------------------------------------------------
  wire single_wire = loopback_select && receiver_source_select;
  assign serial_out_pin = tx_line ^ tx_invert;
  assign serial_out_oe = !single_wire || single_wire_pin_direction;

  // Level request, held while any enabled flag stands
  assign irq_req = (err_flags.overrun && overrun_irq_enable)
                   || (err_flags.noise && noise_irq_enable)
                   || (err_flags.framing && framing_irq_enable)
                   || (err_flags.parity && parity_irq_enable);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $fell(rx_line) && !$past(edge_evt) |-> ##1 rx_edge_flag_q || !$past(clk_en))
    else $error("edge flag not set on active edge");

  chk_break_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && break_detect && lin_break_detect_enable |=> lin_break_flag_q)
    else $error("break flag not set on detected break");

  chk_break_thresh: assert property (@(posedge pclk) disable iff (!presetn)
    break_detect |-> low_cnt_q == brk_thr - 4'h1)
    else $error("break reported at wrong length");

  chk_gate_rx_flags: assert property (@(posedge pclk) disable iff (!presetn)
    lin_break_detect_enable |-> !rx_full_set && !framing_set)
    else $error("receive flags set while break detection on");

  chk_idle_standby: assert property (@(posedge pclk) disable iff (!presetn)
    idle_set && receiver_standby |-> wake_idle_flag_select)
    else $error("idle flag set in standby without select");

  chk_active_clears: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && idle_evt |=> !receiver_active_flag)
    else $error("receiver active not cleared on idle");

  chk_break_len: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en ##1 clk_en |-> tx_load.break_bits ==
      ($past(data_9bit) ? 4'hb : 4'ha) + ($past(long_break_tx) ? 4'h3 : 4'h0))
    else $error("transmit break length wrong");

  chk_ninth_word: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && data_write && data_9bit |=> tx_load.load && tx_load.word[8] == $past(tx_ninth_bit))
    else $error("ninth transmit bit not carried");

  chk_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
    loopback_select && receiver_source_select |-> serial_out_oe == single_wire_pin_direction)
    else $error("single-wire direction wrong");

  chk_irq_overrun: assert property (@(posedge pclk) disable iff (!presetn)
    err_flags.overrun && overrun_irq_enable |-> irq_req)
    else $error("overrun request missing");

  chk_irq_noise: assert property (@(posedge pclk) disable iff (!presetn)
    err_flags.noise && noise_irq_enable |-> irq_req)
    else $error("noise request missing");

  chk_irq_framing: assert property (@(posedge pclk) disable iff (!presetn)
    err_flags.framing && framing_irq_enable |-> irq_req)
    else $error("framing request missing");

  chk_irq_parity: assert property (@(posedge pclk) disable iff (!presetn)
    err_flags.parity && parity_irq_enable |-> irq_req)
    else $error("parity request missing");

  // Request must drop once no enabled flag stands
  chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(err_flags & ctl_ninth_q[3:0])) |-> !irq_req)
    else $error("request without enabled flag");

  chk_ninth_rx: assert property (@(posedge pclk) disable iff (!presetn)
    rx_full_set && data_9bit |=> rx_ninth_bit_q == $past(rx_char.data[8]))
    else $error("ninth receive bit not kept");

endmodule

// *** uls_cfg.svh ***
// Offsets, field positions, reset values and counts for the serial extended status block
// Notes on behaviour
// - With break detection enabled, a received break sets lin_break_flag; writing 1 clears.
// - Active receive edge sets rx_edge_flag; falling normally, rising if inverted; 1 clears.
// - rx_invert flips the receive pin before every receive function, break and idle too.
// - In standby, an idle character sets the idle flag only when wake_idle_flag_select is 1.
// - Sent break is 10 or 11 bit times, or 13 or 14 with long_break_tx.
// - Framing error detection does not depend on long_break_tx.
// - While break detection is enabled, framing and receive-full flags cannot set.
// - Received break threshold is 10 or 11 bits, 11 or 12 with detection enabled.
// - Receiver active sets at a start bit, clears at idle line, and is read-only.
// - In 9-bit mode the ninth received bit is kept in rx_ninth_bit.
// - A data buffer write sends the 9-bit word including tx_ninth_bit in 9-bit mode; in 8-bit mode bit 8 is sent as 0.
// - Single-wire mode: serial_out_pin is input when direction is 0, output when 1.
// - tx_invert flips everything driven on serial_out_pin, idle level included.
// - Overrun flag with overrun_irq_enable requests an interrupt.
// - Noise flag with noise_irq_enable requests an interrupt.
// - Framing flag with framing_irq_enable requests an interrupt.
// - Parity flag with parity_irq_enable requests an interrupt.
// - Frame is 10 bits in 8-bit mode and 11 bits in 9-bit mode.
`ifndef ULS_CFG_SVH
`define ULS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ULS_OFF_LIN_EDGE 12'h000
`define ULS_OFF_NINTH_IRQ 12'h004

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ULS_B_LBK_FLAG 7
`define ULS_B_EDGE_FLAG 6
`define ULS_B_RX_INV 4
`define ULS_B_WAKE_SEL 3
`define ULS_B_LONG_BRK 2
`define ULS_B_LBK_EN 1
`define ULS_B_RX_ACT 0
`define ULS_B_RX_NINTH 7
`define ULS_B_TX_NINTH 6
`define ULS_B_PIN_DIR 5
`define ULS_B_TX_INV 4
`define ULS_B_OR_IE 3
`define ULS_B_NF_IE 2
`define ULS_B_FE_IE 1
`define ULS_B_PF_IE 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ULS_RST_BYTE 8'h00

// ----------------------------------------------------------------
// Bit-time counts
// ----------------------------------------------------------------
`define ULS_FRAME_8 4'ha
`define ULS_FRAME_9 4'hb
`define ULS_BRK_LONG_ADD 4'h3
`define ULS_LBK_ADD 4'h1

`endif

// *** uls_pkg.sv ***
// Types shared by the serial extended status block
package uls_pkg;

  // Receiver monitor states
  typedef enum logic [0:0] {
    ULS_RX_IDLE,
    ULS_RX_ACTIVE
  } uls_rx_state_t;

  // Character handed over by the receive shifter
  typedef struct packed {
    logic done;
    logic stop_fault;
    logic [8:0] data;
  } uls_rx_char_t;

  // Status flags of the first status register
  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } uls_err_flags_t;

  // Word and break length sent to the transmit shifter
  typedef struct packed {
    logic load;
    logic [8:0] word;
    logic [3:0] break_bits;
  } uls_tx_load_t;

endpackage

// *** uls_far_node.sv ***
// Remote serial node model that drives the receive pin of the block
`timescale 1ns/100ps

module uls_far_node (
  input wire logic pclk, // Bus clock
  input wire logic baud_tick, // Bit sample pulse
  output logic line // Level on the receive pin
);
  // -----------------------------------------------------------
  // Bit, frame and break generation
  // -----------------------------------------------------------
  initial line = 1'b1;

  // Changes just after a tick edge, so the next tick samples it
  task automatic put_bit(input logic b);
    begin
      do @(posedge pclk); while (baud_tick !== 1'b1);
      line <= b;
    end
  endtask

  // Start bit, data lsb first, optional ninth bit, stop bit, idle
  task automatic send_frame(input logic [8:0] d, input logic nine, input logic stop);
    int i;
    begin
      put_bit(1'b0);
      for (i = 0; i < 8 + nine; i++) begin
        put_bit(d[i]);
      end
      put_bit(stop);
      put_bit(1'b1);
    end
  endtask

  // Low for n bit times, then back to idle
  task automatic send_low(input int n);
    begin
      repeat (n) put_bit(1'b0);
      put_bit(1'b1);
    end
  endtask
endmodule

// *** tb_uart_lin_ext_status_control.sv ***
// Self-checking bench of the extended status block with a remote node model
`timescale 1ns/100ps
`include "uls_cfg.svh"

module tb_uart_lin_ext_status_control;
  // -----------------------------------------------------------
  // Signals
  // -----------------------------------------------------------
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, baud_tick = 0, data_9bit = 0, receiver_standby = 0;
  logic loopback_select = 0, receiver_source_select = 0, serial_in_pin, rx_line;
  uls_pkg::uls_rx_char_t rx_char = '0;
  uls_pkg::uls_err_flags_t err_flags = '0;
  uls_pkg::uls_tx_load_t tx_load;
  logic rx_full_set, framing_set, idle_set, break_detect, irq_req;
  logic [3:0] frame_bits;
  logic data_write = 0, tx_line = 1, serial_out_pin, serial_out_oe;
  logic [7:0] data_byte = 0;
  logic [1:0] bdiv = 0;
  int miscompares = 0, tests_run = 0, low_cnt = 0, brk_at = 0, brk_n = 0, idle_n = 0;

  uls_ext_status dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick), .data_9bit(data_9bit),
    .receiver_standby(receiver_standby), .loopback_select(loopback_select),
    .receiver_source_select(receiver_source_select), .serial_in_pin(serial_in_pin),
    .rx_line(rx_line), .rx_char(rx_char), .rx_full_set(rx_full_set),
    .framing_set(framing_set), .idle_set(idle_set), .break_detect(break_detect),
    .frame_bits(frame_bits), .err_flags(err_flags), .irq_req(irq_req),
    .data_write(data_write), .data_byte(data_byte), .tx_load(tx_load), .tx_line(tx_line),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

  uls_far_node far_u (.pclk(pclk), .baud_tick(baud_tick), .line(serial_in_pin));

  // -----------------------------------------------------------
  // Clock, bit tick every 4 cycles, and pin monitor
  // -----------------------------------------------------------
  always #2 pclk = ~pclk;

  // Counts sampled low bit times so the break moment is judged independently
  always @(posedge pclk) begin
    bdiv <= bdiv + 2'h1;
    baud_tick <= (bdiv == 2'h3);
    if (serial_in_pin === 1'b1)
      low_cnt <= 0;
    else if (baud_tick === 1'b1)
      low_cnt <= low_cnt + 1;
    if (break_detect === 1'b1) begin
      brk_at <= low_cnt + 1;
      brk_n <= brk_n + 1;
    end
    if (idle_set === 1'b1)
      idle_n <= idle_n + 1;
  end

  // -----------------------------------------------------------
  // Tasks and expectations
  // -----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        miscompares++;
      end
    end
  endtask

  task automatic stop_test;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Setup then access; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100)
        miscompares++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h5a5a5a, v}, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // One data write; word and break length show one edge later
  task automatic tx_go(input logic [7:0] b, input logic [8:0] w, input logic [3:0] bb);
    begin
      @(posedge pclk);
      data_write <= 1'b1;
      data_byte <= b;
      @(posedge pclk);
      data_write <= 1'b0;
      #1;
      chk({tx_load.load, tx_load.word}, {1'b1, w});
      chk(tx_load.break_bits, bb);
    end
  endtask

  function automatic logic [3:0] brk_len(input logic m, input logic add1, input logic add3);
    return 4'd10 + m + add1 + (add3 ? 4'd3 : 4'd0);
  endfunction

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    logic [31:0] r, w;
    logic e;
    logic inv;
    int i;
    void'($urandom(32'h13e63f3c));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ULS_OFF_LIN_EDGE, r);
    chk(r, 32'h0);
    rd(`ULS_OFF_NINTH_IRQ, r);
    chk(r, 32'h0);
    apb(1'b1, 12'h008, 32'hff, r, e);
    chk(e, 1'b1);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({r, e}, {32'h0, 1'b1});
    // Read back with inversion off, so no receive event can disturb the flags
    for (i = 0; i < 4; i++) begin
      w = $urandom();
      wr(`ULS_OFF_LIN_EDGE, w[7:0] & 8'hef);
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r, {24'h0, w[7:0] & 8'h0e});
      wr(`ULS_OFF_NINTH_IRQ, w[15:8]);
      rd(`ULS_OFF_NINTH_IRQ, r);
      chk(r, {24'h0, w[15:8] & 8'h7f});
    end
    // Random pin, polarity and enable combinations
    for (i = 0; i < 12; i++) begin
      w = $urandom();
      wr(`ULS_OFF_NINTH_IRQ, w[15:8]);
      wr(`ULS_OFF_LIN_EDGE, {3'b0, w[16], 4'b0});
      @(posedge pclk);
      err_flags <= w[3:0];
      tx_line <= w[4];
      data_9bit <= w[5];
      loopback_select <= w[6] | i[0];
      receiver_source_select <= w[7] | i[0];
      #1;
      chk(rx_line, serial_in_pin ^ w[16]);
      chk(serial_out_pin, tx_line ^ w[12]);
      chk(irq_req, |(w[3:0] & w[11:8]));
      chk(frame_bits, data_9bit ? 4'd11 : 4'd10);
      if (i[0])
        chk(serial_out_oe, w[13]);
    end
    wr(`ULS_OFF_LIN_EDGE, 8'hc0);
    // Transmit word and break length for every mode
    for (i = 0; i < 8; i++) begin
      w = $urandom();
      wr(`ULS_OFF_NINTH_IRQ, {1'b0, i[2], 6'h0});
      wr(`ULS_OFF_LIN_EDGE, {5'b0, i[1], 2'b0});
      data_9bit <= i[0];
      tx_go(w[7:0], {i[0] & i[2], w[7:0]}, brk_len(i[0], 1'b0, i[1]));
      tx_go(w[15:8], {i[0] & i[2], w[15:8]}, brk_len(i[0], 1'b0, i[1]));
    end
    // Received characters, with and without break detection enabled
    for (i = 0; i < 8; i++) begin
      w = $urandom();
      wr(`ULS_OFF_LIN_EDGE, {5'b0, w[0], i[0], 1'b0});
      @(posedge pclk);
      data_9bit <= i[1];
      rx_char <= {1'b1, i[2], w[9:1]};
      #1;
      chk({rx_full_set, framing_set}, {~i[0], ~i[0] & i[2]});
      @(posedge pclk);
      rx_char.done <= 1'b0;
      rd(`ULS_OFF_NINTH_IRQ, r);
      if (!i[0] && i[1])
        chk(r[7], w[9]);
    end
    // Active edge flag in both polarities; idle receive level is the inverse
    for (i = 0; i < 2; i++) begin
      inv = i[0];
      wr(`ULS_OFF_LIN_EDGE, {3'b0, inv, 4'b0});
      repeat (3) far_u.put_bit(~inv);
      wr(`ULS_OFF_LIN_EDGE, {3'b010, inv, 4'b0});
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[6], 1'b0);
      far_u.put_bit(inv);
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[6], 1'b1);
      wr(`ULS_OFF_LIN_EDGE, {3'b000, inv, 4'b0});
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[6], 1'b1);
      wr(`ULS_OFF_LIN_EDGE, {3'b010, inv, 4'b0});
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[6], 1'b0);
      far_u.put_bit(~inv);
    end
    // Receiver activity and idle flag in standby
    receiver_standby <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(`ULS_OFF_LIN_EDGE, {4'b1100, i[0], 3'b0});
      repeat (14) far_u.put_bit(1'b1);
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[0], 1'b0);
      idle_n = 0;
      fork
        far_u.send_frame({1'b0, 8'($urandom())}, 1'b0, 1'b1);
        begin
          repeat (10) @(posedge pclk);
          rd(`ULS_OFF_LIN_EDGE, r);
          chk(r[0], 1'b1);
        end
      join
      repeat (14) far_u.put_bit(1'b1);
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[0], 1'b0);
      chk(idle_n != 0, i[0]);
    end
    receiver_standby <= 1'b0;
    // Received break threshold in all four modes, flag only when enabled
    for (i = 0; i < 4; i++) begin
      wr(`ULS_OFF_LIN_EDGE, {6'b110000, i[0], 1'b0});
      data_9bit <= i[1];
      brk_n = 0;
      far_u.send_low(brk_len(i[1], i[0], 1'b0) + 2);
      chk(brk_at, brk_len(i[1], i[0], 1'b0));
      chk(brk_n, 1);
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[7], i[0]);
      wr(`ULS_OFF_LIN_EDGE, {6'b100000, i[0], 1'b0});
      rd(`ULS_OFF_LIN_EDGE, r);
      chk(r[7], 1'b0);
    end
    stop_test();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
endmodule
